// file: hw/scir_regs.sv
/*
  Interrupt and control register block of a charger power manager: system event
  flags and mask, charger change flags with mask and roll-up, auxiliary LDO
  control, and write protection of static charger configuration.
  Assumes an I2C slave in front that gives one-cycle read and write strobes with
  a register address, and analog monitors whose inputs are synchronous to clk.
*/
`timescale 1ns/100ps
module scir_regs (
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire logic                         belowPorLevel,
  input  wire logic                         supplyFaultReset,
  input  wire scir_pkg::scir_access_type    access,
  input  wire scir_pkg::scir_sys_event_type sysEvents,
  input  wire logic [7:0]                   chargerHealth,
  output logic      [7:0]                   readData,
  output logic                              cfgWriteEnable,
  output scir_pkg::scir_ldo_ctrl_type       ldoCtrl,
  output logic                              configWriteLock,
  output logic                              irq_out_n
);
  import scir_pkg::*;

  logic [7:0] sysSource_reg;
  logic [7:0] sysMask_reg;
  logic [7:0] chgFlags_reg;
  logic [7:0] chgMask_reg;
  logic [7:0] ldo_reg;
  logic [7:0] lock_reg;
  logic [7:0] sysSet;
  logic [7:0] chgChange;
  logic [7:0] topSource;
  logic       sysReset;
  logic       chgReset;
  logic       chgPending;
  logic       sysPending;

  function automatic logic hit(input scir_access_type acc, input logic [7:0] offset);
    hit = acc.address == offset;
  endfunction

  // Static charger settings sit in one address window; the lock register itself is exempt.
  function automatic logic protectedHit(input logic [7:0] address);
    protectedHit = address >= CFG_FIRST_OFFSET && address <= CFG_LAST_OFFSET
                   && address != LOCK_OFFSET;
  endfunction

  assign sysReset = reset | belowPorLevel;
  assign chgReset = sysReset | supplyFaultReset;

  scir_change_detect #(
    .WIDTH(8)
  ) u_change (
    .clk    (clk),
    .reset  (chgReset),
    .level  (chargerHealth),
    .changed(chgChange)
  );

  always_comb begin
    sysSet = ZERO_BYTE;
    sysSet[UNDERVOLT_BIT] = sysEvents.undervoltFall;
    sysSet[OVERVOLT_BIT]  = sysEvents.overvoltEdge;
    sysSet[THERMAL_BIT]   = sysEvents.thermalEvent;
    sysSet[TESTMODE_BIT]  = sysEvents.testModeEvent;
  end

  // clear on read, new events win.
  always_ff @(posedge clk) begin
    if (sysReset) begin
      sysSource_reg <= SYS_SOURCE_RESET;
    end else if (access.readStrobe && hit(access, SYS_SOURCE_OFFSET)) begin
      sysSource_reg <= sysSet & SYS_SOURCE_USED;
    end else begin
      sysSource_reg <= (sysSource_reg | sysSet) & SYS_SOURCE_USED;
    end
  end

  // low mask bits reset to one.
  always_ff @(posedge clk) begin
    if (sysReset) begin
      sysMask_reg <= SYS_MASK_RESET;
    end else if (access.writeStrobe && hit(access, SYS_MASK_OFFSET)) begin
      sysMask_reg <= access.writeData;
    end
  end

  // charger registers reset on supply faults.
  always_ff @(posedge clk) begin
    if (chgReset) begin
      chgFlags_reg <= CHG_FLAGS_RESET;
    end else if (access.readStrobe && hit(access, CHG_FLAGS_OFFSET)) begin
      chgFlags_reg <= chgChange & CHG_FLAGS_USED;
    end else begin
      chgFlags_reg <= (chgFlags_reg | chgChange) & CHG_FLAGS_USED;
    end
  end

  always_ff @(posedge clk) begin
    if (chgReset) begin
      chgMask_reg <= CHG_MASK_RESET;
    end else if (access.writeStrobe && hit(access, CHG_MASK_OFFSET)) begin
      chgMask_reg <= access.writeData;
    end
  end

  always_ff @(posedge clk) begin
    if (chgReset) begin
      ldo_reg <= AUX_LDO_RESET;
    end else if (access.writeStrobe && hit(access, AUX_LDO_OFFSET)) begin
      ldo_reg <= access.writeData;
    end
  end

  // The lock itself stays writable so software can release it after boot.
  always_ff @(posedge clk) begin
    if (chgReset) begin
      lock_reg <= LOCK_RESET;
    end else if (access.writeStrobe && hit(access, LOCK_OFFSET)) begin
      lock_reg <= access.writeData;
    end
  end

  assign configWriteLock = lock_reg != ZERO_BYTE;

  // lock relies on boot-time setup.
  // Only the protected window is gated, so other writes never stall behind the lock.
  assign cfgWriteEnable = access.writeStrobe
                          && !(configWriteLock && protectedHit(access.address));

  assign ldoCtrl = scir_ldo_ctrl_type'({ldo_reg[1:0], ldo_reg[3:2], ldo_reg[4], ldo_reg[5],
                                        ldo_reg[6], ldo_reg[7]});

  assign chgPending = |(chgFlags_reg & ~chgMask_reg);
  assign sysPending = |(sysSource_reg & ~sysMask_reg);

  always_comb begin
    topSource = ZERO_BYTE;
    topSource[TOP_CHARGER_BIT] = chgPending;
    topSource[TOP_SYSTEM_BIT]  = |sysSource_reg;
  end

  // Pin is registered so it changes one cycle after the flag state it reflects.
  always_ff @(posedge clk) begin
    if (chgReset) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= !(chgPending || sysPending);
    end
  end

  // Read data is registered; unmapped addresses return zero.
  always_ff @(posedge clk) begin
    if (sysReset) begin
      readData <= ZERO_BYTE;
    end else if (access.readStrobe) begin
      case (access.address)
        TOP_SOURCE_OFFSET: readData <= topSource;
        SYS_SOURCE_OFFSET: readData <= sysSource_reg;
        SYS_MASK_OFFSET:   readData <= sysMask_reg;
        CHG_FLAGS_OFFSET:  readData <= chgFlags_reg;
        CHG_MASK_OFFSET:   readData <= chgMask_reg;
        CHG_HEALTH_OFFSET: readData <= chargerHealth;
        AUX_LDO_OFFSET:    readData <= ldo_reg;
        LOCK_OFFSET:       readData <= lock_reg;
        default:           readData <= ZERO_BYTE;
      endcase
    end
  end

  // System flags are registered, so each event is checked one cycle later.
  // Registers are still unknown before the first reset edge, hence the disables.
  undervolt_flag_a: assert property (
    @(posedge clk) disable iff (sysReset)
    sysEvents.undervoltFall
    |=> sysSource_reg[UNDERVOLT_BIT])
    else $error("undervoltage event not flagged");
  overvolt_flag_a: assert property (
    @(posedge clk) disable iff (sysReset)
    sysEvents.overvoltEdge
    |=> sysSource_reg[OVERVOLT_BIT])
    else $error("overvoltage edge not flagged");
  thermal_flag_a: assert property (
    @(posedge clk) disable iff (sysReset)
    sysEvents.thermalEvent
    |=> sysSource_reg[THERMAL_BIT])
    else $error("thermal event not flagged");
  test_mode_flag_a: assert property (
    @(posedge clk) disable iff (sysReset)
    sysEvents.testModeEvent
    |=> sysSource_reg[TESTMODE_BIT])
    else $error("test mode event not flagged");
  sys_reserved_a: assert property (
    @(posedge clk) disable iff (sysReset)
    (sysSource_reg & ~SYS_SOURCE_USED) == ZERO_BYTE)
    else $error("reserved system bits nonzero");
  sys_mask_reset_a: assert property (
    @(posedge clk)
    $fell(sysReset)
    |-> sysMask_reg == SYS_MASK_RESET)
    else $error("system mask reset value wrong");
  sys_mask_write_a: assert property (
    @(posedge clk) disable iff (sysReset)
    access.writeStrobe && hit(access, SYS_MASK_OFFSET)
    |=> sysMask_reg == $past(access.writeData))
    else $error("system mask write lost");
  sys_read_clear_a: assert property (
    @(posedge clk) disable iff (sysReset)
    access.readStrobe && hit(access, SYS_SOURCE_OFFSET) && sysSet == ZERO_BYTE
    |=> sysSource_reg == ZERO_BYTE)
    else $error("system flags not cleared by read");
  sys_top_bit_a: assert property (
    @(posedge clk) disable iff (sysReset)
    sysSource_reg != ZERO_BYTE
    |-> topSource[TOP_SYSTEM_BIT])
    else $error("system flag not shown in top source");
  por_reset_a: assert property (
    @(posedge clk)
    belowPorLevel
    |=> sysSource_reg == SYS_SOURCE_RESET && sysMask_reg == SYS_MASK_RESET)
    else $error("system registers not reset below power-on level");

  // A change that lands on the clearing read must survive it, so the checks
  // compare against the change vector of the cycle before.
  chg_flag_set_a: assert property (
    @(posedge clk) disable iff (chgReset)
    (chgChange & CHG_FLAGS_USED) != ZERO_BYTE
    |=> (chgFlags_reg & $past(chgChange)) == ($past(chgChange) & CHG_FLAGS_USED))
    else $error("charger change not flagged");
  chg_change_kept_a: assert property (
    @(posedge clk) disable iff (chgReset)
    access.readStrobe && hit(access, CHG_FLAGS_OFFSET) && chgChange != ZERO_BYTE
    |=> (chgFlags_reg & $past(chgChange)) == ($past(chgChange) & CHG_FLAGS_USED))
    else $error("charger change lost during read");
  chg_reserved_a: assert property (
    @(posedge clk) disable iff (chgReset)
    (chgFlags_reg & ~CHG_FLAGS_USED) == ZERO_BYTE)
    else $error("reserved charger bit set");
  chg_read_clear_a: assert property (
    @(posedge clk) disable iff (chgReset)
    access.readStrobe && hit(access, CHG_FLAGS_OFFSET) && chgChange == ZERO_BYTE
    |=> chgFlags_reg == ZERO_BYTE)
    else $error("charger flags not cleared by read");
  chg_top_drop_a: assert property (
    @(posedge clk) disable iff (chgReset)
    chgFlags_reg == ZERO_BYTE
    |-> !topSource[TOP_CHARGER_BIT])
    else $error("top charger bit stays with no flags");
  chg_top_bit_a: assert property (
    @(posedge clk) disable iff (chgReset)
    (chgFlags_reg & ~chgMask_reg) != ZERO_BYTE
    |-> topSource[TOP_CHARGER_BIT])
    else $error("unmasked charger flag not in top source");
  masked_irq_a: assert property (
    @(posedge clk) disable iff (chgReset)
    (chgFlags_reg & ~chgMask_reg) == ZERO_BYTE && (sysSource_reg & ~sysMask_reg) == ZERO_BYTE
    |=> irq_out_n)
    else $error("interrupt asserted with all sources masked");
  unmasked_irq_a: assert property (
    @(posedge clk) disable iff (chgReset)
    chgPending
    |=> !irq_out_n)
    else $error("unmasked charger flag did not interrupt");
  fault_reset_a: assert property (
    @(posedge clk)
    supplyFaultReset
    |=> chgFlags_reg == CHG_FLAGS_RESET && chgMask_reg == CHG_MASK_RESET
        && ldo_reg == AUX_LDO_RESET)
    else $error("charger registers not reset on supply fault");

  // The packing check guards the cast that fans the control byte out to fields.
  // Lock checks cover both sides of the gate, since either failure is silent.
  ldo_reset_a: assert property (
    @(posedge clk)
    $fell(chgReset)
    |-> ldo_reg == AUX_LDO_RESET)
    else $error("LDO control reset value wrong");
  ldo_discharge_a: assert property (
    @(posedge clk)
    $fell(chgReset)
    |-> ldoCtrl.aDischarge && ldoCtrl.bDischarge)
    else $error("LDO discharge not on after reset");
  ldo_fields_a: assert property (
    @(posedge clk) disable iff (chgReset)
    {ldoCtrl.bEnable, ldoCtrl.aEnable, ldoCtrl.bDischarge, ldoCtrl.aDischarge,
     ldoCtrl.bVoltage, ldoCtrl.aVoltage} == ldo_reg)
    else $error("LDO control fields misplaced");
  lock_block_a: assert property (
    @(posedge clk) disable iff (chgReset)
    configWriteLock && protectedHit(access.address)
    |-> !cfgWriteEnable)
    else $error("locked configuration write passed");
  unlocked_write_a: assert property (
    @(posedge clk) disable iff (chgReset)
    access.writeStrobe && !configWriteLock
    |-> cfgWriteEnable)
    else $error("unlocked write was blocked");

endmodule // scir_regs

// file: hw/scir_pkg.sv
/*
  Package for the system and charger interrupt register block: register offsets,
  field positions, reset values and the carrier structs shared by the block files.
  Assumes an upstream I2C slave that presents decoded register reads and writes.
*/
package scir_pkg;

  localparam logic [7:0] TOP_SOURCE_OFFSET  = 8'h22;
  localparam logic [7:0] SYS_SOURCE_OFFSET  = 8'h24;
  localparam logic [7:0] SYS_MASK_OFFSET    = 8'h26;
  localparam logic [7:0] CHG_FLAGS_OFFSET   = 8'hb0;
  localparam logic [7:0] CHG_MASK_OFFSET    = 8'hb1;
  localparam logic [7:0] CHG_HEALTH_OFFSET  = 8'hb2;
  localparam logic [7:0] AUX_LDO_OFFSET     = 8'hc6;
  localparam logic [7:0] CFG_FIRST_OFFSET   = 8'hb7;
  localparam logic [7:0] CFG_LAST_OFFSET    = 8'hbf;
  localparam logic [7:0] LOCK_OFFSET        = 8'hbd;

  localparam logic [7:0] SYS_SOURCE_RESET   = 8'h00;
  localparam logic [7:0] SYS_MASK_RESET     = 8'h7f;
  localparam logic [7:0] CHG_FLAGS_RESET    = 8'h00;
  localparam logic [7:0] CHG_MASK_RESET     = 8'hff;
  localparam logic [7:0] AUX_LDO_RESET      = 8'h75;
  localparam logic [7:0] SYS_SOURCE_USED    = 8'h87;
  localparam logic [7:0] CHG_FLAGS_USED     = 8'hfd;
  localparam logic [7:0] LOCK_RESET         = 8'h00;
  localparam logic [7:0] ZERO_BYTE          = 8'h00;

  localparam int UNDERVOLT_BIT  = 0;
  localparam int OVERVOLT_BIT   = 1;
  localparam int THERMAL_BIT    = 2;
  localparam int TESTMODE_BIT   = 7;
  localparam int TOP_CHARGER_BIT = 0;
  localparam int TOP_SYSTEM_BIT  = 2;

  typedef struct packed {
    logic       readStrobe;
    logic       writeStrobe;
    logic [7:0] address;
    logic [7:0] writeData;
  } scir_access_type;

  typedef struct packed {
    logic undervoltFall;
    logic overvoltEdge;
    logic thermalEvent;
    logic testModeEvent;
  } scir_sys_event_type;

  typedef struct packed {
    logic [1:0] aVoltage;
    logic [1:0] bVoltage;
    logic       aDischarge;
    logic       bDischarge;
    logic       aEnable;
    logic       bEnable;
  } scir_ldo_ctrl_type;

  typedef enum logic [1:0] {
    LDO_4V85 = 2'b00,
    LDO_4V90 = 2'b01,
    LDO_4V95 = 2'b10,
    LDO_3V30 = 2'b11
  } scir_ldo_level_type;

endpackage

// file: hw/scir_change_detect.sv
/*
  Change detector for the charger health bits: each bit is compared with its
  value one clock earlier and a one-cycle pulse marks every change.
  Assumes the health bits are synchronous to clk.
*/
`timescale 1ns/100ps
module scir_change_detect #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] changed
);
  import scir_pkg::*;

  logic [WIDTH-1:0] level_reg;

  // Remember the last level so any edge, rising or falling, is seen.
  always_ff @(posedge clk) begin
    if (reset) begin
      level_reg <= '0;
    end else begin
      level_reg <= level;
    end
  end

  assign changed = reset ? '0 : (level ^ level_reg);

endmodule // scir_change_detect

// file: testbench/scir_host_model.sv
/*
  Host model: issues one-cycle register reads and writes on the decoded access
  port, queueing the data each read must return and the write-enable each write
  must produce. Assumes the bench clock and inputs changed at the falling edge.
*/
`timescale 1ns/100ps
module scir_host_model (
  input  wire logic                clk,
  output scir_pkg::scir_access_type access
);
  import scir_pkg::*;
  logic [7:0] expQ[$];
  logic       enQ[$];
  initial access = '0;
  // A gap cycle between strobes keeps two accesses from merging into one.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic e);
    @(negedge clk);
    enQ.push_back(e);
    access <= '{1'b0, 1'b1, a, d};
    @(negedge clk);
    access <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    expQ.push_back(e);
    access <= '{1'b1, 1'b0, a, ~a};
    @(negedge clk);
    access <= '{1'b0, 1'b0, ~a, a};
  endtask
endmodule // scir_host_model

// file: testbench/test_system_charger_interrupt_regs.sv
/*
  Self-checking bench for the interrupt and control register block.
  Assumes the host model drives accesses; this module drives monitors and resets.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin nMismatch++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module test_system_charger_interrupt_regs;
  import scir_pkg::*;
  logic clk, reset, belowPor, fault, cfgEn, lock, irqN;
  scir_access_type    access;
  scir_sys_event_type sysEv;
  scir_ldo_ctrl_type  ldo;
  logic [7:0] health, rdData, d;
  int nMismatch = 0, nCompared = 0, cycles = 0;

  scir_host_model host (.clk(clk), .access(access));
  scir_regs dut (.clk(clk), .reset(reset), .belowPorLevel(belowPor),
    .supplyFaultReset(fault), .access(access), .sysEvents(sysEv),
    .chargerHealth(health), .readData(rdData), .cfgWriteEnable(cfgEn),
    .ldoCtrl(ldo), .configWriteLock(lock), .irq_out_n(irqN));

  task automatic reportAndStop;
    $display("compared %0d mismatched %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Read data is registered, so it is judged at the falling edge after the strobe.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      nMismatch++;
      reportAndStop();
    end
    if (access.writeStrobe) `CHK(cfgEn, host.enQ.pop_front())
    if (access.readStrobe) begin
      @(negedge clk);
      `CHK(rdData, host.expQ.pop_front())
    end
  end

  initial begin
    reset = 1'b1; belowPor = 1'b0; fault = 1'b0; sysEv = '0; health = 8'h00;
    void'($urandom(32'hc3ccd875));
    repeat (20) @(negedge clk);
    reset = 1'b0;
    host.rd(8'h24, 8'h00);
    host.rd(8'h26, 8'h7f);
    host.rd(8'hb0, 8'h00);
    host.rd(8'hc6, 8'h75);
    host.rd(8'h50, 8'h00);
    `CHK(irqN, 1'b1)
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      @(negedge clk) sysEv = 4'b1000 >> i;
      @(negedge clk) sysEv = '0;
      repeat (2) @(negedge clk);
      `CHK(irqN, i != 3)
      host.rd(8'h22, 8'h04);
      host.rd(8'h24, i == 3 ? 8'h80 : 8'h01 << i);
      host.rd(8'h24, 8'h00);
    end
    d = 8'($urandom);
    host.wr(8'h26, d, 1'b1);
    host.rd(8'h26, d);
    host.wr(8'h26, 8'hff, 1'b1);
    $display("test system events done");
    host.wr(8'hb1, 8'h00, 1'b1);
    for (int k = 0; k < 8; k++) begin
      if (k == 1) continue;
      @(negedge clk) health = health ^ (8'h01 << k);
      repeat (3) @(negedge clk);
      `CHK(irqN, 1'b0)
      host.rd(8'h22, 8'h01);
      host.rd(8'hb0, 8'h01 << k);
      host.rd(8'hb0, 8'h00);
      repeat (2) @(negedge clk);
      `CHK(irqN, 1'b1)
      host.rd(8'h22, 8'h00);
    end
    host.wr(8'hb1, 8'hff, 1'b1);
    @(negedge clk) health = health ^ 8'h10;
    repeat (3) @(negedge clk);
    `CHK(irqN, 1'b1)
    host.rd(8'h22, 8'h00);
    // A health change on the clearing read must stay pending.
    fork
      host.rd(8'hb0, 8'h10);
      @(negedge clk) health = health ^ 8'h20;
    join
    host.rd(8'hb0, 8'h20);
    $display("test charger flags done");
    for (int v = 0; v < 4; v++) begin
      d = 8'($urandom);
      d[3:0] = {v[1:0], v[1:0]};
      host.wr(8'hc6, d, 1'b1);
      host.rd(8'hc6, d);
      `CHK({ldo.bEnable, ldo.aEnable, ldo.bDischarge, ldo.aDischarge, ldo.bVoltage, ldo.aVoltage}, d)
    end
    $display("test ldo control done");
    host.wr(8'hb8, 8'h33, 1'b1);
    host.wr(8'hbd, 8'h01, 1'b1);
    `CHK(lock, 1'b1)
    host.wr(8'hb8, 8'h55, 1'b0);
    host.wr(8'hbd, 8'h00, 1'b1);
    host.wr(8'hb8, 8'h55, 1'b1);
    $display("test write lock done");
    host.wr(8'h26, 8'h5a, 1'b1);
    @(negedge clk) fault = 1'b1;
    @(negedge clk) fault = 1'b0;
    host.rd(8'hc6, 8'h75);
    host.rd(8'h26, 8'h5a);
    @(negedge clk) belowPor = 1'b1;
    @(negedge clk) belowPor = 1'b0;
    host.rd(8'h26, 8'h7f);
    repeat (2) @(negedge clk);
    $display("test reset inputs done");
    reportAndStop();
  end
endmodule // test_system_charger_interrupt_regs
